// File: hw/mps_pkg.sv
// constants and carrier types for the midrange/peripheral select decoder
package mps_pkg;
	// register byte offsets on the control port
	localparam logic [7:0]  PERIPH_BASE_OFS = 8'ha4;
	localparam logic [7:0]  MID_BASE_OFS    = 8'ha6;
	localparam logic [7:0]  AUX_CFG_OFS     = 8'ha8;
	// register values after reset: peripheral base 0 in io space, upper pins carrying A2 and A1
	localparam logic [15:0] PERIPH_BASE_RST = 16'h0000;
	localparam logic [15:0] MID_BASE_RST    = 16'h0000;
	localparam logic [15:0] AUX_CFG_RST     = 16'h8038;
	// auxiliary bits that always read as one
	localparam logic [15:0] AUX_FIXED_ONES  = 16'h8038;
	// field positions
	localparam int MID_BASE_HI      = 15;
	localparam int MID_BASE_LO      = 9;
	localparam int PERIPH_BASE_HI   = 15;
	localparam int PERIPH_BASE_LO   = 7;
	localparam int SIZE_HI          = 14;
	localparam int SIZE_LO          = 8;
	localparam int PIN_SEL_BIT      = 7;
	localparam int MEM_IO_BIT       = 6;
	localparam int WAIT_HIGH_BIT    = 3;
	localparam int READY_MODE_BIT   = 2;
	localparam int WAIT_HI          = 1;
	localparam int WAIT_LO          = 0;
	// decode geometry
	localparam logic [19:0] MID_UNIT_SIZE   = 20'h02000;
	localparam logic [19:0] PERIPH_SPAN     = 20'h00700;
	localparam logic [2:0]  PERIPH_HOLE     = 3'h4;
	localparam logic [3:0]  CNT_ZERO        = 4'h0;

	// one processor bus cycle request
	typedef struct packed {
		logic [19:0] addr;
		logic        is_mem;
	} mps_cycle_t;

	// chip select group, active low
	typedef struct packed {
		logic [3:0] mid_n;
		logic [3:0] lo_n;
		logic [1:0] up_n;
	} mps_sel_t;

	typedef enum logic [0:0] {
		ST_IDLE,
		ST_ACTIVE
	} mps_state_t;
endpackage : mps_pkg

// File: hw/mps_select.sv
// midrange and peripheral chip select decoder with wait-state and ready control
`timescale 1ns/10ps
`default_nettype none

module mps_select (
	input  wire logic              clk_sys,
	input  wire logic              reset_n,
	input  wire logic [7:0]        reg_addr,
	input  wire logic [15:0]       reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic [15:0]            reg_rdata,
	input  wire logic              cyc_start,
	input  wire mps_pkg::mps_cycle_t cyc_req,
	input  wire logic              ext_ready,
	output logic                   cyc_done,
	output logic [3:0]             midrange_selects_n,
	output logic [3:0]             lower_peripheral_selects_n,
	output logic [1:0]             upper_peripheral_selects_n
);
	logic [15:0]          periph_q;
	logic [15:0]          mid_q;
	logic [15:0]          aux_q;
	logic [15:0]          rdata_q;
	logic                 mid_seen_q;
	logic                 aux_seen_q;
	logic                 rdy_s1_q;
	logic                 rdy_s2_q;
	mps_pkg::mps_state_t  state_q;
	logic [3:0]           cnt_q;
	logic                 need_rdy_q;
	logic                 done_q;
	mps_pkg::mps_sel_t    sel_q;
	logic [3:0]           cnt_d;
	logic                 need_rdy_d;
	mps_pkg::mps_sel_t    sel_d;

	// register access decode
	wire hit_periph = (reg_addr == mps_pkg::PERIPH_BASE_OFS);
	wire hit_mid    = (reg_addr == mps_pkg::MID_BASE_OFS);
	wire hit_aux    = (reg_addr == mps_pkg::AUX_CFG_OFS);
	wire touch      = reg_wr | reg_rd;
	wire [15:0] rd_mux = hit_periph ? periph_q :
		hit_mid ? mid_q :
		hit_aux ? aux_q : 16'h0000;

	// register storage; aux reserved ones stay one on readback
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			periph_q <= mps_pkg::PERIPH_BASE_RST;
			mid_q    <= mps_pkg::MID_BASE_RST;
			aux_q    <= mps_pkg::AUX_CFG_RST;
		end
		else if (reg_wr)
		begin
			if (hit_periph)
				periph_q <= reg_wdata;
			if (hit_mid)
				mid_q <= reg_wdata;
			if (hit_aux)
				aux_q <= reg_wdata | mps_pkg::AUX_FIXED_ONES;
		end
	end

	// read data valid only in the cycle after the strobe
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
			rdata_q <= 16'h0000;
		else
			rdata_q <= reg_rd ? rd_mux : 16'h0000;
	end

	// either a read or a write arms the midrange selects
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			mid_seen_q <= 1'b0;
			aux_seen_q <= 1'b0;
		end
		else
		begin
			if (touch && hit_mid)
				mid_seen_q <= 1'b1;
			if (touch && hit_aux)
				aux_seen_q <= 1'b1;
		end
	end

	// ready pin comes from outside; two flops before use
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rdy_s1_q <= 1'b0;
			rdy_s2_q <= 1'b0;
		end
		else
		begin
			rdy_s1_q <= ext_ready;
			rdy_s2_q <= rdy_s1_q;
		end
	end

	// midrange decode
	wire [6:0]  size_oh  = aux_q[mps_pkg::SIZE_HI:mps_pkg::SIZE_LO];
	wire        size_ok  = (size_oh != 7'h00) && ((size_oh & (size_oh - 7'h01)) == 7'h00);
	wire [19:0] mid_base = {mid_q[mps_pkg::MID_BASE_HI:mps_pkg::MID_BASE_LO], 13'h0000};
	// total size is the unit shifted by the one-hot position
	wire [19:0] mid_size = mps_pkg::MID_UNIT_SIZE * {13'h0000, size_oh};
	wire [19:0] mid_mask = ~(mid_size - 20'h00001);
	wire [19:0] mid_off  = cyc_req.addr & ~mid_mask;
	// quarter index is the top two offset bits of the block
	wire [19:0] mid_qtr  = mid_size >> 2;
	wire [1:0]  mid_idx  = (mid_off >= (mid_qtr * 20'h00003)) ? 2'h3 :
		(mid_off >= (mid_qtr << 1)) ? 2'h2 :
		(mid_off >= mid_qtr) ? 2'h1 : 2'h0;
	wire        mid_en   = mid_seen_q & aux_seen_q;
	wire        mid_hit  = mid_en && size_ok && cyc_req.is_mem &&
		(((cyc_req.addr ^ mid_base) & mid_mask) == 20'h00000);
	wire [3:0]  mid_wait = {2'h0, mid_q[mps_pkg::WAIT_HI:mps_pkg::WAIT_LO]};
	wire        mid_rdy  = ~mid_q[mps_pkg::READY_MODE_BIT];

	// peripheral decode
	wire        pin_cs   = aux_q[mps_pkg::PIN_SEL_BIT];
	wire        space_ok = (cyc_req.is_mem == aux_q[mps_pkg::MEM_IO_BIT]);
	wire [19:0] per_base = {periph_q[mps_pkg::PERIPH_BASE_HI:mps_pkg::PERIPH_BASE_LO],
		11'h000};
	// io space is 16 bits wide, so the upper nibble must be zero
	wire        io_ok    = cyc_req.is_mem || (cyc_req.addr[19:16] == 4'h0);
	wire [19:0] per_off  = cyc_req.addr - per_base;
	wire [2:0]  slice    = per_off[10:8];
	wire        per_in   = space_ok && io_ok && (cyc_req.addr >= per_base) &&
		(per_off < mps_pkg::PERIPH_SPAN) && (slice != mps_pkg::PERIPH_HOLE);
	wire        lo_hit   = per_in && (slice < 3'h4);
	wire        up_hit   = per_in && (slice > 3'h4) && pin_cs;
	wire [2:0]  lo_code  = {periph_q[mps_pkg::WAIT_HIGH_BIT],
		periph_q[mps_pkg::WAIT_HI:mps_pkg::WAIT_LO]};
	wire [3:0]  lo_wait  = (lo_code == 3'h4) ? 4'h5 :
		(lo_code == 3'h5) ? 4'h7 :
		(lo_code == 3'h6) ? 4'h9 :
		(lo_code == 3'h7) ? 4'hf : {1'b0, lo_code};
	wire        lo_rdy   = ~periph_q[mps_pkg::READY_MODE_BIT];
	wire [3:0]  up_wait  = {2'h0, aux_q[mps_pkg::WAIT_HI:mps_pkg::WAIT_LO]};
	wire        up_rdy   = ~aux_q[mps_pkg::READY_MODE_BIT];

	// select, waits and ready need for a new cycle; midrange wins overlaps
	always_comb
	begin
		sel_d      = '{mid_n: 4'hf, lo_n: 4'hf, up_n: 2'h3};
		cnt_d      = mps_pkg::CNT_ZERO;
		need_rdy_d = 1'b0;
		if (mid_hit)
		begin
			sel_d.mid_n[mid_idx] = 1'b0;
			cnt_d      = mid_wait;
			need_rdy_d = mid_rdy;
		end
		else if (lo_hit)
		begin
			sel_d.lo_n[slice[1:0]] = 1'b0;
			cnt_d      = lo_wait;
			need_rdy_d = lo_rdy;
		end
		else if (up_hit)
		begin
			// slice 5 sits on the A1 pin (bit 0), slice 6 on the A2 pin (bit 1)
			sel_d.up_n[slice[1]] = 1'b0;
			cnt_d      = up_wait;
			need_rdy_d = up_rdy;
		end
		// without the pin selector the upper pins carry A2 and A1
		if (!pin_cs)
			sel_d.up_n = cyc_req.addr[2:1];
	end

	// cycle may finish once the count is spent and ready is satisfied
	wire finish = (state_q == mps_pkg::ST_ACTIVE) && (cnt_q == mps_pkg::CNT_ZERO) &&
		(!need_rdy_q || rdy_s2_q);

	// bus cycle sequencer
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			state_q    <= mps_pkg::ST_IDLE;
			cnt_q      <= mps_pkg::CNT_ZERO;
			need_rdy_q <= 1'b0;
			done_q     <= 1'b0;
			sel_q      <= '{mid_n: 4'hf, lo_n: 4'hf, up_n: 2'h3};
		end
		else
		begin
			done_q <= finish;
			unique case (state_q)
				mps_pkg::ST_IDLE:
				begin
					if (cyc_start)
					begin
						state_q    <= mps_pkg::ST_ACTIVE;
						cnt_q      <= cnt_d;
						need_rdy_q <= need_rdy_d;
						sel_q      <= sel_d;
					end
				end
				mps_pkg::ST_ACTIVE:
				begin
					if (finish)
					begin
						state_q      <= mps_pkg::ST_IDLE;
						sel_q.mid_n  <= 4'hf;
						sel_q.lo_n   <= 4'hf;
						// address lines keep their value; chip selects release
						if (pin_cs)
							sel_q.up_n <= 2'h3;
					end
					else if (cnt_q != mps_pkg::CNT_ZERO)
						cnt_q <= cnt_q - 4'h1;
				end
			endcase
		end
	end

	assign reg_rdata                  = rdata_q;
	assign cyc_done                   = done_q;
	assign midrange_selects_n         = sel_q.mid_n;
	assign lower_peripheral_selects_n = sel_q.lo_n;
	assign upper_peripheral_selects_n = sel_q.up_n;

	// helper: cycles spent in the active state of this access
	logic [4:0] elapsed_q;
	logic [3:0] waits_q;
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			elapsed_q <= 5'h00;
			waits_q   <= 4'h0;
		end
		else if (state_q == mps_pkg::ST_IDLE && cyc_start)
		begin
			elapsed_q <= 5'h00;
			waits_q   <= cnt_d;
		end
		else if (state_q == mps_pkg::ST_ACTIVE && elapsed_q != 5'h1f)
			elapsed_q <= elapsed_q + 5'h01;
	end

	// checks
	mid_arm_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
		!(mid_seen_q && aux_seen_q) |-> (midrange_selects_n == 4'hf))
		else $error("midrange select active before both registers accessed");
	wait_len_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
		finish |-> (elapsed_q >= {1'b0, waits_q}))
		else $error("cycle ended before programmed wait states");
	no_rdy_len_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(state_q == mps_pkg::ST_ACTIVE && !need_rdy_q) |-> ##[0:15] finish)
		else $error("ready-ignored cycle overran its wait count");
	rdy_gate_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(finish && need_rdy_q) |-> $past(ext_ready, 2))
		else $error("cycle ended without required external ready");
	one_hot_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
		$onehot0(~{midrange_selects_n, lower_peripheral_selects_n}))
		else $error("more than one select active");
	addr_pins_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(state_q == mps_pkg::ST_IDLE && cyc_start && !pin_cs)
		|=> (upper_peripheral_selects_n == $past(cyc_req.addr[2:1])))
		else $error("upper pins do not carry A2/A1");
	space_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(state_q == mps_pkg::ST_IDLE && cyc_start && !space_ok)
		|=> (lower_peripheral_selects_n == 4'hf))
		else $error("peripheral select in wrong bus space");
	io_range_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(state_q == mps_pkg::ST_IDLE && cyc_start && !cyc_req.is_mem
		&& cyc_req.addr[19:16] != 4'h0) |=> (lower_peripheral_selects_n == 4'hf))
		else $error("io decode outside 64k");
	lo_wait_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(state_q == mps_pkg::ST_IDLE && cyc_start && !mid_hit && lo_hit && lo_code == 3'h7)
		|=> (cnt_q == 4'hf))
		else $error("lower wait code 7 not 15 waits");
	done_pulse_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
		cyc_done |=> !cyc_done)
		else $error("done held longer than one cycle");

	// midrange and upper wait counts, upper and lower ready needs and upper pin mapping latched; no midrange select with an invalid size field
	mid_wait_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(state_q == mps_pkg::ST_IDLE && cyc_start && mid_hit)
		|=> (cnt_q == {2'h0, $past(mid_q[mps_pkg::WAIT_HI:mps_pkg::WAIT_LO])}))
		else $error("midrange wait count not taken from base register");
	up_wait_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(state_q == mps_pkg::ST_IDLE && cyc_start && !mid_hit && up_hit)
		|=> (cnt_q == {2'h0, $past(aux_q[mps_pkg::WAIT_HI:mps_pkg::WAIT_LO])}))
		else $error("upper select wait count not taken from aux register");
	up_rdy_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(state_q == mps_pkg::ST_IDLE && cyc_start && !mid_hit && up_hit)
		|=> (need_rdy_q == !$past(aux_q[mps_pkg::READY_MODE_BIT])))
		else $error("upper select ready need does not follow aux ready bit");
	lo_rdy_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(state_q == mps_pkg::ST_IDLE && cyc_start && !mid_hit && lo_hit)
		|=> (need_rdy_q == !$past(periph_q[mps_pkg::READY_MODE_BIT])))
		else $error("lower select ready need does not follow ready bit");
	up_slot_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(state_q == mps_pkg::ST_IDLE && cyc_start && !mid_hit && up_hit)
		|=> (upper_peripheral_selects_n == (($past(slice) == 3'h5) ? 2'h2 : 2'h1)))
		else $error("upper select drives the wrong pin");
	size_bad_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(state_q == mps_pkg::ST_IDLE && cyc_start && !size_ok)
		|=> (midrange_selects_n == 4'hf))
		else $error("midrange select with invalid size field");

	mid_cyc_c: cover property (@(posedge clk_sys) disable iff (!reset_n)
		finish && midrange_selects_n != 4'hf && waits_q == 4'h3);
	lo_cyc_c: cover property (@(posedge clk_sys) disable iff (!reset_n)
		finish && lower_peripheral_selects_n != 4'hf && need_rdy_q);
	up_cyc_c: cover property (@(posedge clk_sys) disable iff (!reset_n)
		finish && pin_cs && upper_peripheral_selects_n != 2'h3);
	io_cyc_c: cover property (@(posedge clk_sys) disable iff (!reset_n)
		finish && !pin_cs && lower_peripheral_selects_n != 4'hf);
	mid_rdy_c: cover property (@(posedge clk_sys) disable iff (!reset_n)
		finish && need_rdy_q && midrange_selects_n != 4'hf);
endmodule : mps_select

`default_nettype wire

// File: tb/mps_ready_model.sv
// external device model that answers ready some cycles after being selected
`timescale 1ns/10ps
`default_nettype none
module mps_ready_model (
	input  wire logic       clk_sys,
	input  wire logic       reset_n,
	input  wire logic [9:0] sel_n,
	input  wire logic [3:0] delay,
	output logic            ext_ready
);
	logic [3:0] cnt_q;

	// counts cycles while selected; a released device starts again from zero
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
			cnt_q <= 4'h0;
		else if (&sel_n)
			cnt_q <= 4'h0;
		else if (cnt_q != 4'hf)
			cnt_q <= cnt_q + 4'h1;
	end

	// ready only while selected and late enough, low when idle
	assign ext_ready = !(&sel_n) && (cnt_q >= delay);
endmodule : mps_ready_model
`default_nettype wire

// File: tb/mps_select_tb_top.sv
// self-checking bench for the midrange and peripheral select decoder
`timescale 1ns/10ps
`default_nettype none
module mps_select_tb_top;
	logic                clk_sys;
	logic                reset_n;
	logic [7:0]          reg_addr;
	logic [15:0]         reg_wdata;
	logic                reg_wr;
	logic                reg_rd;
	logic [15:0]         reg_rdata;
	logic                cyc_start;
	mps_pkg::mps_cycle_t cyc_req;
	logic                ext_ready;
	logic                cyc_done;
	wire  [9:0]          sel_n;
	logic [3:0]          rdy_dly;
	int                  error_cnt;
	int                  n_compared;
	int                  ticks;

	mps_select dut (
		.clk_sys                    (clk_sys),
		.reset_n                    (reset_n),
		.reg_addr                   (reg_addr),
		.reg_wdata                  (reg_wdata),
		.reg_wr                     (reg_wr),
		.reg_rd                     (reg_rd),
		.reg_rdata                  (reg_rdata),
		.cyc_start                  (cyc_start),
		.cyc_req                    (cyc_req),
		.ext_ready                  (ext_ready),
		.cyc_done                   (cyc_done),
		.midrange_selects_n         (sel_n[9:6]),
		.lower_peripheral_selects_n (sel_n[5:2]),
		.upper_peripheral_selects_n (sel_n[1:0])
	);

	mps_ready_model dev (
		.clk_sys   (clk_sys),
		.reset_n   (reset_n),
		.sel_n     (sel_n),
		.delay     (rdy_dly),
		.ext_ready (ext_ready)
	);

	// clock and a hang guard far above the expected run length
	always #12.5 clk_sys = ~clk_sys;
	always @(posedge clk_sys)
	begin
		ticks++;
		if (ticks == 20000)
		begin
			error_cnt++;
			close_out();
		end
	end

	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_compared++;
		if (g !== e)
		begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask : wr

	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1;
		chk("rdata", e, reg_rdata);
	endtask : rd

	// one bus cycle: selects seen in cycle 1, done within lo..hi cycles
	task automatic cyc(input logic [19:0] a, input logic m, input logic [9:0] es,
		input int lo, input int hi);
		int n;
		n = 1;
		@(posedge clk_sys);
		cyc_req   <= '{addr: a, is_mem: m};
		cyc_start <= 1'b1;
		@(posedge clk_sys);
		cyc_start <= 1'b0;
		#1;
		chk("selects", {6'h00, es}, {6'h00, sel_n});
		while (cyc_done !== 1'b1 && n < 40)
		begin
			@(posedge clk_sys);
			#1;
			n++;
		end
		chk("done_early", 16'h0001, 16'(n >= lo));
		chk("done_late", 16'h0001, 16'(n <= hi));
	endtask : cyc

	task automatic t_gate();
		wr(8'ha6, 16'h2006);
		cyc(20'h20000, 1'b1, 10'h3fc, 2, 2);
		rd(8'ha4, 16'h0000);
		rd(8'ha6, 16'h2006);
		rd(8'ha8, 16'h8038);
		rd(8'ha2, 16'h0000);
		wr(8'ha8, 16'h84fd);
		rd(8'ha8, 16'h84fd);
		$display("test gate done");
	endtask : t_gate

	task automatic t_mid();
		for (int i = 0; i < 4; i++)
			cyc(20'h20000 + 20'(i) * 20'h02000, 1'b1, {~(4'h1 << i), 6'h3f}, 4, 4);
		cyc(20'h28000, 1'b1, 10'h3ff, 2, 2);
		cyc(20'h1ffff, 1'b1, 10'h3ff, 2, 2);
		cyc(20'h20000, 1'b0, 10'h3ff, 2, 2);
		for (int w = 0; w < 4; w++)
		begin
			wr(8'ha6, 16'h2004 | 16'(w));
			cyc(20'h27fff, 1'b1, 10'h1ff, w + 2, w + 2);
		end
		wr(8'ha6, 16'h2001);
		cyc(20'h27fff, 1'b1, 10'h1ff, 10, 15);
		$display("test mid done");
	endtask : t_mid

	// base at 512k so every size is aligned
	task automatic t_size();
		wr(8'ha6, 16'h8005);
		for (int k = 0; k < 7; k++)
		begin
			wr(8'ha8, 16'h80fd | (16'h0100 << k));
			cyc(20'h80000 + (20'h02000 << k) - 20'h1, 1'b1, 10'h1ff, 3, 3);
			if (k < 6)
				cyc(20'h80000 + (20'h02000 << k), 1'b1, 10'h3ff, 2, 2);
		end
		$display("test size done");
	endtask : t_size

	task automatic t_periph();
		int tbl[8] = '{0, 1, 2, 3, 5, 7, 9, 15};
		logic [9:0] es;
		for (int c = 0; c < 8; c++)
		begin
			wr(8'ha4, 16'h4004 | 16'((((c >> 2) & 1) << 3) | (c & 3)));
			cyc(20'h40000, 1'b1, 10'h3fb, tbl[c] + 2, tbl[c] + 2);
		end
		wr(8'ha4, 16'h4004);
		for (int j = 0; j < 8; j++)
		begin
			es = (j < 4) ? {4'hf, ~(4'h1 << j), 2'h3} : (j == 5) ? 10'h3fe :
				(j == 6) ? 10'h3fd : 10'h3ff;
			cyc(20'h40000 + 20'(j) * 20'h00100, 1'b1, es, 2 + int'(j == 5 || j == 6),
				2 + int'(j == 5 || j == 6));
		end
		wr(8'ha4, 16'h4000);
		cyc(20'h40000, 1'b1, 10'h3fb, 10, 15);
		// upper selects: three waits with ready ignored, then one wait with ready required
		wr(8'ha8, 16'hc0ff);
		cyc(20'h40600, 1'b1, 10'h3fd, 5, 5);
		wr(8'ha8, 16'hc0f9);
		cyc(20'h40500, 1'b1, 10'h3fe, 10, 15);
		$display("test periph done");
	endtask : t_periph

	// io space with the upper pins carrying address bits
	task automatic t_io();
		wr(8'ha8, 16'h803d);
		wr(8'ha4, 16'h0104);
		cyc(20'h01102, 1'b0, 10'h3f5, 2, 2);
		cyc(20'h01102, 1'b1, 10'h3fd, 2, 2);
		cyc(20'h11102, 1'b0, 10'h3fd, 2, 2);
		$display("test io done");
	endtask : t_io

	task automatic close_out();
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : close_out

	initial
	begin
		clk_sys   = 1'b0;
		reset_n   = 1'b0;
		reg_addr  = 8'h00;
		reg_wdata = 16'h0000;
		reg_wr    = 1'b0;
		reg_rd    = 1'b0;
		cyc_start = 1'b0;
		cyc_req   = '0;
		rdy_dly   = 4'h9;
		repeat (5) @(posedge clk_sys);
		reset_n <= 1'b1;
		t_gate();
		t_mid();
		t_size();
		t_periph();
		t_io();
		close_out();
	end
endmodule : mps_select_tb_top
`default_nettype wire
